// ### rtl/tpsm_pkg.sv
// Shared constants and carrier types for the transmit channel scheduler
package tpsm_pkg;
   // ==========================================================
   // Object map
   localparam int NCH = 3;
   localparam logic [15:0] IDX_TXCOM = 16'h1800;
   localparam logic [15:0] IDX_JITTER = 16'h3000;
   localparam logic [7:0] SUB_HIGHEST = 8'h00;
   localparam logic [7:0] SUB_COB = 8'h01;
   localparam logic [7:0] SUB_TYPE = 8'h02;
   localparam logic [7:0] SUB_GAP = 8'h03;
   localparam logic [7:0] SUB_RSVD = 8'h04;
   localparam logic [7:0] SUB_CYCLE = 8'h05;
   localparam logic [7:0] HIGHEST_SUB = 8'h05;
   // ==========================================================
   // Identifier word and transmission types
   localparam int COB_INVALID_BIT = 31;
   localparam int COB_EXT_BIT = 29;
   localparam logic [2:0][10:0] COB_BASE = {11'h380, 11'h280, 11'h180};
   localparam logic [7:0] TYPE_RESET = 8'hFF;
   localparam logic [7:0] TYPE_SYNC_CHG = 8'h00;
   localparam logic [7:0] TYPE_SYNC_MAX = 8'hF0;
   localparam logic [7:0] TYPE_RSVD_LO = 8'hF1;
   localparam logic [7:0] TYPE_RSVD_HI = 8'hFB;
   localparam logic [7:0] TYPE_SYNC_RTR = 8'hFC;
   localparam logic [7:0] TYPE_ASYNC_RTR = 8'hFD;
   localparam logic [7:0] TYPE_EVENT_LO = 8'hFE;
   // ==========================================================
   // Timing
   localparam int CLK_HZ = 50_000_000;
   localparam int US_TIME = 1;
   localparam int US_CYCLES = CLK_HZ / 1_000_000 * US_TIME;
   localparam int MS_TIME = 1;
   localparam int MS_CYCLES = CLK_HZ / 1000 * MS_TIME;
   localparam logic [15:0] GAP_UNITS_PER_MS = 16'h000A;
   localparam logic [15:0] JITTER_MAX_US = 16'h4268;
   // ==========================================================
   // Bit-rate selection
   localparam logic [3:0] BAUD_CODE_LO = 4'h3;
   localparam logic [3:0] BAUD_CODE_HI = 4'h8;
   localparam logic [5:0][10:0] BAUD_KBPS =
      {11'h3E8, 11'h1F4, 11'h0FA, 11'h07D, 11'h064, 11'h032};
   // ==========================================================
   // Carriers
   typedef struct packed {
      logic [10:0] id;
      logic [63:0] data;
   } tpsm_frame_t;
   typedef struct packed {
      logic req;
      logic wr;
      logic [15:0] index;
      logic [7:0] sub;
      logic [31:0] wdata;
   } tpsm_req_t;
   typedef struct packed {
      logic ack;
      logic abort;
      logic [31:0] rdata;
   } tpsm_rsp_t;
endpackage : tpsm_pkg

// ### rtl/tpsm_scheduler.sv
// Transmit channel scheduler with SYNC timing monitor
//
// Contract
// - Channel identifiers default to 0x180/0x280/0x380 plus node number, writable.
// - Identifier bit 31 set marks a channel non-existent; it raises no new send requests, but a frame already pending still goes out.
// - Identifier bit 29 must be 0; 11-bit id in bits 0..10.
// - Factory state: first channel valid, second and third not valid.
// - Transmission type resets to 255 (event driven) and stays writable.
// - Type 0: sample at SYNC, send only if data differs from last sent.
// - Type n in 1..240: sample and send on every n-th SYNC.
// - Type 252: sample at SYNC, send that sample on a later remote request.
// - Type 253: sample current data and send on a remote request.
// - Types 254 and 255: send on data change or event time expiry.
// - Inhibit time is the least gap between async sends; changes wait.
// - Inhibit field is 16 bits, units of 100 us.
// - Inhibit applied in ms, last decimal digit dropped; below 10 is zero.
// - Event time 0..65535 ms sets retransmit interval of unchanged data.
// - With zero inhibit time the channel sends only on data change.
// - Any access to sub-index 4 is answered with an abort.
// - SYNC outside period plus or minus tolerance raises a communication error.
// - Tolerance 0..17000 us, clamped to half the cycle period.
// - Zero tolerance disables SYNC monitoring; nonzero enables it.
// - Bit-rate codes 3..8 select 50..1000 kbit/s, same on all nodes.
module tpsm_scheduler #(
   parameter int MS_CYCLES = tpsm_pkg::MS_CYCLES
) (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Node setup
   input wire logic [6:0] node_id,
   input wire logic [3:0] baud_code,
   input wire logic [31:0] cycle_period_us,
   // Object access port
   input wire tpsm_pkg::tpsm_req_t obj_req,
   output tpsm_pkg::tpsm_rsp_t obj_rsp,
   // Bus events
   input wire logic sync_seen,
   input wire logic rtr_seen,
   input wire logic [10:0] rtr_id,
   // Application data per channel
   input wire logic [tpsm_pkg::NCH-1:0][63:0] app_data,
   // Frame to the controller
   output logic tx_valid,
   input wire logic tx_ready,
   output tpsm_pkg::tpsm_frame_t tx_frame,
   // Status
   output logic comm_err,
   output logic [10:0] baud_kbps
);
   typedef struct packed {
      logic [31:0] cob;
      logic [7:0] ttype;
      logic [15:0] gap;
      logic [15:0] cyc;
      logic [63:0] last;
      logic [63:0] smp;
      logic [7:0] scnt;
      logic [12:0] gap_left;
      logic [15:0] cyc_left;
      logic pend;
      logic armed;
   } tpsm_ch_t;

   typedef struct packed {
      tpsm_ch_t [tpsm_pkg::NCH-1:0] ch;
      logic [15:0] jitter;
      logic [31:0] ms_div;
      logic [7:0] us_div;
      logic [23:0] since;
      logic [23:0] meas;
      logic seen;
      logic meas_ok;
      logic tx_valid;
      tpsm_pkg::tpsm_frame_t frame;
      tpsm_pkg::tpsm_rsp_t rsp;
      logic comm_err;
      logic [10:0] baud;
   } tpsm_st_t;

   tpsm_st_t r;
   tpsm_st_t next_r;

   // ==========================================================
   // Helpers
   function automatic logic [10:0] baud_of(input logic [3:0] code);
      if (code >= tpsm_pkg::BAUD_CODE_LO && code <= tpsm_pkg::BAUD_CODE_HI)
         baud_of = tpsm_pkg::BAUD_KBPS[code - tpsm_pkg::BAUD_CODE_LO];
      else
         baud_of = 11'h000;
   endfunction : baud_of

   function automatic logic [12:0] gap_ms(input logic [15:0] gap);
      gap_ms = 13'(gap / tpsm_pkg::GAP_UNITS_PER_MS);
   endfunction : gap_ms

   function automatic logic is_async(input logic [7:0] t);
      is_async = t >= tpsm_pkg::TYPE_EVENT_LO;
   endfunction : is_async

   // ==========================================================
   // Next state
   always_comb begin
      logic ms_tick;
      logic us_tick;
      logic sent;
      logic hit;
      logic [1:0] ci;
      logic [31:0] per;
      logic [31:0] tol;
      tpsm_ch_t c;
      ms_tick = 1'b0;
      us_tick = 1'b0;
      sent = 1'b0;
      hit = 1'b0;
      ci = 2'h0;
      per = 32'h0000_0000;
      tol = 32'h0000_0000;
      c = '0;
      next_r = r;
      next_r.comm_err = 1'b0;
      next_r.rsp = '0;
      next_r.baud = baud_of(baud_code);

      // Time bases
      if (r.ms_div == 32'(MS_CYCLES - 1)) begin
         next_r.ms_div = '0;
         ms_tick = 1'b1;
      end else begin
         next_r.ms_div = r.ms_div + 32'h1;
      end
      if (r.us_div == 8'(tpsm_pkg::US_CYCLES - 1)) begin
         next_r.us_div = '0;
         us_tick = 1'b1;
      end else begin
         next_r.us_div = r.us_div + 8'h01;
      end
      if (us_tick && r.since != '1)
         next_r.since = r.since + 24'h1;

      // Frame handoff; a held frame blocks all channels
      if (r.tx_valid && tx_ready)
         next_r.tx_valid = 1'b0;

      for (int i = 0; i < tpsm_pkg::NCH; i++) begin
         c = r.ch[i];
         if (ms_tick && c.gap_left != '0)
            c.gap_left = c.gap_left - 13'h1;
         if (ms_tick && c.cyc_left != '0)
            c.cyc_left = c.cyc_left - 16'h1;
         // Lowest channel wins the free slot
         if (!next_r.tx_valid && !sent && c.pend) begin
            sent = 1'b1;
            next_r.tx_valid = 1'b1;
            next_r.frame.id = c.cob[10:0];
            next_r.frame.data = c.smp;
            c.pend = 1'b0;
            c.last = c.smp;
            c.gap_left = gap_ms(c.gap);
            c.cyc_left = c.cyc;
         end
         // Events; a new request wins over the send that cleared pend
         if (!c.cob[tpsm_pkg::COB_INVALID_BIT]) begin
            if (sync_seen) begin
               if (c.ttype == tpsm_pkg::TYPE_SYNC_CHG) begin
                  if (app_data[i] != c.last) begin
                     c.smp = app_data[i];
                     c.pend = 1'b1;
                  end
               end else if (c.ttype <= tpsm_pkg::TYPE_SYNC_MAX) begin
                  if (c.scnt + 8'h01 >= c.ttype) begin
                     c.scnt = 8'h00;
                     c.smp = app_data[i];
                     c.pend = 1'b1;
                  end else begin
                     c.scnt = c.scnt + 8'h01;
                  end
               end else if (c.ttype == tpsm_pkg::TYPE_SYNC_RTR) begin
                  c.smp = app_data[i];
                  c.armed = 1'b1;
               end
            end
            if (rtr_seen && rtr_id == c.cob[10:0]) begin
               if (c.ttype == tpsm_pkg::TYPE_SYNC_RTR && c.armed) begin
                  c.armed = 1'b0;
                  c.pend = 1'b1;
               end else if (c.ttype == tpsm_pkg::TYPE_ASYNC_RTR) begin
                  c.smp = app_data[i];
                  c.pend = 1'b1;
               end
            end
            // Cyclic resend only runs with a nonzero gap
            if (is_async(c.ttype) && !c.pend && c.gap_left == '0 &&
                (app_data[i] != c.last ||
                 (c.cyc != '0 && c.cyc_left == '0 &&
                  gap_ms(c.gap) != '0))) begin
               c.smp = app_data[i];
               c.pend = 1'b1;
            end
         end
         next_r.ch[i] = c;
      end

      // SYNC timing monitor
      if (sync_seen) begin
         per = (cycle_period_us != '0) ? cycle_period_us : 32'(r.meas);
         tol = (32'(r.jitter) > (per >> 1)) ? (per >> 1) : 32'(r.jitter);
         if (r.seen && r.jitter != '0 &&
             (cycle_period_us != '0 || r.meas_ok) &&
             (32'(r.since) + tol < per ||
              32'(r.since) > per + tol))
            next_r.comm_err = 1'b1;
         next_r.meas = r.since;
         next_r.meas_ok = r.seen;
         next_r.seen = 1'b1;
         next_r.since = '0;
      end

      // Object access, answered one cycle after the request
      if (obj_req.req) begin
         next_r.rsp.ack = 1'b1;
         next_r.rsp.abort = 1'b1;
         hit = obj_req.index >= tpsm_pkg::IDX_TXCOM &&
               obj_req.index < tpsm_pkg::IDX_TXCOM + 16'(tpsm_pkg::NCH);
         ci = 2'(obj_req.index - tpsm_pkg::IDX_TXCOM);
         if (hit) begin
            c = next_r.ch[ci];
            unique case (obj_req.sub)
               tpsm_pkg::SUB_HIGHEST: begin
                  next_r.rsp.rdata = 32'(tpsm_pkg::HIGHEST_SUB);
                  next_r.rsp.abort = obj_req.wr;
               end
               tpsm_pkg::SUB_COB: begin
                  next_r.rsp.rdata = c.cob;
                  if (!obj_req.wr)
                     next_r.rsp.abort = 1'b0;
                  else if (!obj_req.wdata[tpsm_pkg::COB_EXT_BIT]) begin
                     c.cob = obj_req.wdata;
                     next_r.rsp.abort = 1'b0;
                  end
               end
               tpsm_pkg::SUB_TYPE: begin
                  next_r.rsp.rdata = 32'(c.ttype);
                  if (!obj_req.wr)
                     next_r.rsp.abort = 1'b0;
                  else if (obj_req.wdata[31:8] == '0 &&
                           !(obj_req.wdata[7:0] >= tpsm_pkg::TYPE_RSVD_LO &&
                             obj_req.wdata[7:0] <=
                             tpsm_pkg::TYPE_RSVD_HI)) begin
                     c.ttype = obj_req.wdata[7:0];
                     c.scnt = 8'h00;
                     c.armed = 1'b0;
                     next_r.rsp.abort = 1'b0;
                  end
               end
               tpsm_pkg::SUB_GAP: begin
                  next_r.rsp.rdata = 32'(c.gap);
                  next_r.rsp.abort = 1'b0;
                  if (obj_req.wr)
                     c.gap = obj_req.wdata[15:0];
               end
               tpsm_pkg::SUB_CYCLE: begin
                  next_r.rsp.rdata = 32'(c.cyc);
                  next_r.rsp.abort = 1'b0;
                  if (obj_req.wr) begin
                     c.cyc = obj_req.wdata[15:0];
                     c.cyc_left = obj_req.wdata[15:0];
                  end
               end
               default: next_r.rsp.abort = 1'b1;
            endcase
            next_r.ch[ci] = c;
         end else if (obj_req.index == tpsm_pkg::IDX_JITTER &&
                      obj_req.sub == 8'h00) begin
            next_r.rsp.rdata = 32'(r.jitter);
            if (!obj_req.wr)
               next_r.rsp.abort = 1'b0;
            else if (obj_req.wdata <= 32'(tpsm_pkg::JITTER_MAX_US)) begin
               next_r.jitter = obj_req.wdata[15:0];
               next_r.rsp.abort = 1'b0;
            end
         end
      end
   end

   // ==========================================================
   // State register
   always_ff @(posedge sys_clk) begin
      if (!resetn) begin
         r <= '0;
         for (int i = 0; i < tpsm_pkg::NCH; i++) begin
            r.ch[i].cob <= {(i != 0), 20'h00000,
               11'(tpsm_pkg::COB_BASE[i] + 11'(node_id))};
            r.ch[i].ttype <= tpsm_pkg::TYPE_RESET;
         end
      end else begin
         r <= next_r;
      end
   end

   assign tx_valid = r.tx_valid;
   assign tx_frame = r.frame;
   assign obj_rsp = r.rsp;
   assign comm_err = r.comm_err;
   assign baud_kbps = r.baud;

   // ==========================================================
   // Checks
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!resetn);

   sequence s_sub4_req;
      obj_req.req && obj_req.sub == tpsm_pkg::SUB_RSVD &&
      obj_req.index >= tpsm_pkg::IDX_TXCOM &&
      obj_req.index < tpsm_pkg::IDX_TXCOM + 16'(tpsm_pkg::NCH);
   endsequence
   sequence s_abort_ans;
      obj_rsp.ack && obj_rsp.abort;
   endsequence

   chk_sub4_abort: assert property (s_sub4_req |=> s_abort_ans)
      else $error("sub-index 4 access not aborted");
   chk_ext_refused: assert property (obj_req.req && obj_req.wr &&
      obj_req.sub == tpsm_pkg::SUB_COB && obj_req.wdata[29] &&
      obj_req.index == tpsm_pkg::IDX_TXCOM |=> s_abort_ans ##1
      !r.ch[0].cob[29])
      else $error("extended identifier accepted");
   chk_rsvd_type: assert property (obj_req.req && obj_req.wr &&
      obj_req.sub == tpsm_pkg::SUB_TYPE && obj_req.index ==
      tpsm_pkg::IDX_TXCOM && obj_req.wdata == 32'h0000_00F5
      |=> s_abort_ans and $stable(r.ch[0].ttype))
      else $error("reserved transmission type accepted");
   chk_reset_state: assert property ($rose(resetn) |->
      r.ch[0].ttype == 8'hFF && !r.ch[0].cob[31] && r.ch[1].cob[31] &&
      r.ch[2].cob[31] && r.ch[0].cob[10:0] == 11'h180 + 11'(node_id))
      else $error("wrong channel defaults after reset");
   chk_invalid_quiet: assert property (r.ch[2].cob[31] && !r.ch[2].pend
      |=> !r.ch[2].pend)
      else $error("non-existent channel requested a send");
   chk_sync_nochg: assert property (sync_seen && !r.ch[0].cob[31] &&
      r.ch[0].ttype == 8'h00 && app_data[0] == r.ch[0].last &&
      !r.ch[0].pend && !obj_req.req |=> !r.ch[0].pend)
      else $error("unchanged type 0 data was scheduled");
   chk_gap_load: assert property (r.ch[0].pend && !r.tx_valid
      |=> r.tx_valid && r.ch[0].gap_left == gap_ms(r.ch[0].gap) &&
      r.ch[0].cyc_left == r.ch[0].cyc)
      else $error("gap or event timer not reloaded on send");
   chk_gap_hold: assert property ($past(is_async(r.ch[0].ttype)) &&
      $rose(r.ch[0].pend) |-> r.ch[0].gap_left == '0)
      else $error("async send requested inside the gap");
   chk_err_cause: assert property (comm_err |-> $past(sync_seen) &&
      $past(r.jitter) != '0)
      else $error("communication error without monitored sync");
   chk_baud_map: assert property (baud_code == 4'h8 |=>
      baud_kbps == 11'h3E8)
      else $error("bit-rate code 8 not mapped to 1000");
endmodule : tpsm_scheduler

// ### sim/tpsm_ctrl_model.sv
// Behavioural model of the bus controller taking frames from the scheduler
module tpsm_ctrl_model (
   // Clock and reset
   input wire logic sys_clk,
   input wire logic resetn,
   // Pace: high when an acceptance completes makes the controller stall before the next acceptance
   input wire logic slow,
   // Frame handshake
   input wire logic tx_valid,
   output logic tx_ready
);
   timeunit 1ns;
   timeprecision 1ps;
   int wait_left;
   initial begin
      tx_ready = 1'b0;
      wait_left = 0;
   end
   // ==========================================================
   // Acceptance
   // Ready is raised only after an offered frame has been seen at an edge,
   // so a stalled frame must stand unchanged for several cycles
   always @(posedge sys_clk) begin
      #1;
      if (!resetn || tx_ready) begin
         tx_ready = 1'b0;
         wait_left = slow ? 4 : 0;
      end else if (tx_valid) begin
         if (wait_left == 0) begin
            tx_ready = 1'b1;
         end else begin
            wait_left--;
         end
      end
   end
endmodule : tpsm_ctrl_model

// ### sim/tpsm_tb.sv
// Self-checking bench for the transmit channel scheduler
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   typedef struct {
      logic [10:0] id;
      logic [63:0] data;
      int earliest;
      logic abort;
      logic [31:0] rdata;
      bit chk;
   } tpsm_note_t;
   localparam int KBPS [10] = '{0, 0, 0, 50, 100, 125, 250, 500, 1000, 0};
   logic sys_clk, resetn, sync_seen, rtr_seen, tx_ready, tx_valid;
   logic comm_err, slow;
   logic [6:0] node_id;
   logic [3:0] baud_code;
   logic [31:0] cycle_period_us;
   logic [10:0] rtr_id, baud_kbps;
   logic [2:0][63:0] app_data;
   tpsm_pkg::tpsm_req_t obj_req;
   tpsm_pkg::tpsm_rsp_t obj_rsp;
   tpsm_pkg::tpsm_frame_t tx_frame;
   int bad_count = 0;
   int compares = 0;
   int cyc = 0;
   int errs = 0;
   integer seed;
   tpsm_note_t rq[$];
   tpsm_note_t fq[$];

   // A short millisecond keeps the timed cases inside the run budget
   tpsm_scheduler #(.MS_CYCLES(50)) tpsm_scheduler_inst (
      .sys_clk(sys_clk), .resetn(resetn), .node_id(node_id),
      .baud_code(baud_code), .cycle_period_us(cycle_period_us),
      .obj_req(obj_req), .obj_rsp(obj_rsp), .sync_seen(sync_seen),
      .rtr_seen(rtr_seen), .rtr_id(rtr_id), .app_data(app_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .tx_frame(tx_frame),
      .comm_err(comm_err), .baud_kbps(baud_kbps));
   tpsm_ctrl_model tpsm_ctrl_model_inst (
      .sys_clk(sys_clk), .resetn(resetn), .slow(slow),
      .tx_valid(tx_valid), .tx_ready(tx_ready));

   initial begin
      sys_clk = 1'b0;
      forever #10 sys_clk = ~sys_clk;
   end
   // ==========================================================
   // Checking
   task automatic check(input bit ok, input string msg);
      compares++;
      if (!ok) begin
         bad_count++;
         $display("BAD %0t %s", $time, msg);
      end
   endtask : check
   task automatic print_verdict();
      $display("compares %0d mismatches %0d", compares, bad_count);
      if (bad_count == 0 && compares > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask : print_verdict
   task automatic cmp_rsp(input tpsm_note_t n);
      check(obj_rsp.abort === n.abort &&
         (!n.chk || obj_rsp.rdata === n.rdata), "object response");
   endtask : cmp_rsp
   task automatic cmp_frame(input tpsm_note_t n);
      check(tx_frame.id === n.id && tx_frame.data === n.data &&
         cyc >= n.earliest, "frame content or timing");
   endtask : cmp_frame
   always @(posedge sys_clk) begin
      cyc <= cyc + 1;
      if (comm_err === 1'b1) errs++;
      if (obj_rsp.ack === 1'b1) begin
         if (rq.size() == 0) check(0, "unexpected response");
         else cmp_rsp(rq.pop_front());
      end
      if (tx_valid === 1'b1 && tx_ready === 1'b1) begin
         if (fq.size() == 0) check(0, "unexpected frame");
         else cmp_frame(fq.pop_front());
      end
   end
   initial begin
      #1_900_000;
      check(0, "watchdog");
      print_verdict();
   end
   // ==========================================================
   // Drivers
   task automatic tick(input int n);
      repeat (n) @(posedge sys_clk);
      #2;
   endtask : tick
   task automatic obj(input bit wr, input logic [15:0] idx,
         input logic [7:0] sub, input logic [31:0] wd, input bit ab,
         input logic [31:0] rd);
      tpsm_note_t n;
      n = '{default: 0};
      n.abort = ab;
      n.rdata = rd;
      n.chk = !wr && !ab;
      rq.push_back(n);
      obj_req = '{1'b1, wr, idx, sub, wd};
      tick(1);
      obj_req.req = 1'b0;
      tick(1);
   endtask : obj
   task automatic exp_frame(input int ch, input logic [10:0] id,
         input int dly);
      tpsm_note_t n;
      n = '{default: 0};
      n.id = id;
      n.data = app_data[ch];
      n.earliest = cyc + dly;
      fq.push_back(n);
   endtask : exp_frame
   task automatic chg(input int ch);
      app_data[ch] = {$random(seed), $random(seed)};
   endtask : chg
   task automatic pulse(input bit rtr, input logic [10:0] id);
      sync_seen = !rtr;
      rtr_seen = rtr;
      rtr_id = id;
      tick(1);
      sync_seen = 1'b0;
      rtr_seen = 1'b0;
   endtask : pulse
   task automatic sync_after(input int us);
      tick(us * 50 - 1);
      pulse(0, '0);
   endtask : sync_after
   task automatic drain(input string name);
      int k;
      k = 0;
      while (fq.size() + rq.size() != 0 && k < 2000) begin
         tick(1);
         k++;
      end
      if (k == 2000) begin
         check(0, "queue not drained");
         print_verdict();
      end
      $display("done %s", name);
   endtask : drain
   // ==========================================================
   // Scenarios
   initial begin
      seed = 32'hf917;
      resetn = 1'b0;
      obj_req = '0;
      sync_seen = 1'b0;
      rtr_seen = 1'b0;
      rtr_id = '0;
      slow = 1'b0;
      node_id = 7'h2A;
      baud_code = 4'h3;
      cycle_period_us = 32'h28;
      app_data = '0;
      repeat (10) @(posedge sys_clk);
      #2;
      resetn = 1'b1;
      for (int c = 0; c < 3; c++) begin
         obj(0, 16'(16'h1800 + c), 8'h00, '0, 0, 32'h5);
         obj(0, 16'(16'h1800 + c), 8'h01, '0, 0, {c != 0, 20'h0,
            11'(11'h1AA + 11'h100 * c)});
         obj(0, 16'(16'h1800 + c), 8'h02, '0, 0, 32'hFF);
         obj(0, 16'(16'h1800 + c), 8'h03, '0, 0, 32'h0);
         obj(0, 16'(16'h1800 + c), 8'h05, '0, 0, 32'h0);
         obj(0, 16'(16'h1800 + c), 8'h04, '0, 1, '0);
         obj(1, 16'(16'h1800 + c), 8'h04, 32'h1, 1, '0);
         obj(1, 16'(16'h1800 + c), 8'h00, 32'h1, 1, '0);
      end
      obj(0, 16'h3000, 8'h00, '0, 0, 32'h0);
      drain("reset values");
      for (int b = 2; b < 10; b++) begin
         baud_code = 4'(b);
         tick(2);
         check(baud_kbps === 11'(KBPS[b]), "bit rate");
      end
      obj(1, 16'h3000, 8'h00, 32'hA, 0, '0);
      errs = 0;
      pulse(0, '0);
      sync_after(40);
      sync_after(25);
      sync_after(40);
      obj(1, 16'h3000, 8'h00, 32'h4269, 1, '0);
      obj(1, 16'h3000, 8'h00, 32'h4268, 0, '0);
      sync_after(65);
      sync_after(55);
      obj(1, 16'h3000, 8'h00, 32'h0, 0, '0);
      sync_after(10);
      // Measured period from here on
      cycle_period_us = 32'h0;
      sync_after(40);
      obj(1, 16'h3000, 8'h00, 32'hA, 0, '0);
      sync_after(40);
      sync_after(25);
      obj(1, 16'h3000, 8'h00, 32'h0, 0, '0);
      tick(3);
      check(errs === 3, "sync error count");
      drain("sync timing");
      obj(1, 16'h1800, 8'h05, 32'h2, 0, '0);
      chg(0);
      exp_frame(0, 11'h1AA, 1);
      chg(1);
      tick(250);
      drain("event send");
      // Cycle time first: a run-out timer would send at once when
      // the nonzero gap makes cyclic sending live
      obj(1, 16'h1800, 8'h05, 32'h3, 0, '0);
      obj(1, 16'h1800, 8'h03, 32'h14, 0, '0);
      obj(0, 16'h1800, 8'h03, '0, 0, 32'h14);
      chg(0);
      exp_frame(0, 11'h1AA, 0);
      tick(6);
      chg(0);
      exp_frame(0, 11'h1AA, 45);
      exp_frame(0, 11'h1AA, 140);
      slow = 1'b1;
      drain("gap and cycle");
      obj(1, 16'h1800, 8'h05, 32'h0, 0, '0);
      obj(1, 16'h1800, 8'h03, 32'h0, 0, '0);
      obj(1, 16'h1800, 8'h02, 32'h0, 0, '0);
      for (int t = 241; t < 252; t++) obj(1, 16'h1800, 8'h02, 32'(t), 1, '0);
      obj(0, 16'h1800, 8'h02, '0, 0, 32'h0);
      obj(1, 16'h1800, 8'h01, 32'h2000_01AA, 1, '0);
      pulse(0, '0);
      tick(20);
      chg(0);
      tick(20);
      exp_frame(0, 11'h1AA, 0);
      pulse(0, '0);
      drain("sync on change");
      // Type first: a valid type 255 channel would send its changed data
      obj(1, 16'h1801, 8'h02, 32'h2, 0, '0);
      obj(1, 16'h1801, 8'h01, 32'h123, 0, '0);
      for (int s = 0; s < 2; s++) begin
         pulse(0, '0);
         tick(10);
         chg(1);
         exp_frame(1, 11'h123, 0);
         pulse(0, '0);
         tick(10);
         chg(1);
      end
      drain("every nth sync");
      obj(1, 16'h1801, 8'h01, 32'h8000_0123, 0, '0);
      obj(1, 16'h1802, 8'h01, 32'h355, 0, '0);
      obj(1, 16'h1802, 8'h02, 32'hFC, 0, '0);
      chg(2);
      pulse(0, '0);
      tick(1);
      pulse(0, '0);
      exp_frame(2, 11'h355, 0);
      chg(2);
      pulse(1, 11'h356);
      tick(10);
      pulse(1, 11'h355);
      obj(1, 16'h1802, 8'h02, 32'hFD, 0, '0);
      chg(2);
      exp_frame(2, 11'h355, 0);
      pulse(1, 11'h355);
      obj(1, 16'h1802, 8'h02, 32'hFE, 0, '0);
      chg(2);
      exp_frame(2, 11'h355, 0);
      drain("remote request types");
      print_verdict();
   end
endmodule : tb
